// ### rsh_ctrl.sv
// Purpose: active reference choice and holdover control for the first loop
// Assumes: lock flags, rail flags and pins are asynchronous to pclk; exit check done outside
// Notes: one always_comb builds the next state, one always_ff stores it
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module rsh_ctrl #(
  parameter int LEVEL_W = 10,
  parameter int DIV_W   = 16
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               pd_tick,
  input  wire logic               loop1_raw_lock,
  input  wire logic               loop2_lock_flag,
  input  wire logic               exit_ok,
  input  wire logic [LEVEL_W-1:0] tune_level,
  input  wire logic               select_pin_a,
  input  wire logic               select_pin_b,
  output logic                    ref_input_b_active,
  output logic                    holdover,
  output logic                    loop1_lock_flag,
  output logic                    loop1_pump_hiz,
  output logic      [LEVEL_W-1:0] loop1_pump_level,
  output logic                    lock_status_pin
);

  initial begin
    if (LEVEL_W < 1 || LEVEL_W > 16 || DIV_W < 1 || DIV_W > 16) begin
      $error("rsh_ctrl: unsupported width");
    end
  end

  typedef struct packed {
    logic [31:0]        ctrl;
    logic [31:0]        hold;
    logic [LEVEL_W-1:0] upper;
    logic [LEVEL_W-1:0] lower;
    logic [LEVEL_W-1:0] manual;
    logic [LEVEL_W-1:0] tracked;
    logic [DIV_W-1:0]   div_cnt;
    logic [2:0]         lock_sync;
    logic [3:0]         pin_sync;
    logic [1:0]         rail_sync;
    logic               b_active;
    rsh_pkg::rsh_state_t st;
    logic               hold_on;
    logic               lock_out;
    logic               ld_pin;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } rsh_state_all_t;

  rsh_state_all_t      cur;
  rsh_state_all_t      next_s;
  rsh_pkg::rsh_apb_req_t req;

  function automatic logic is_auto(input logic [2:0] p);
    is_auto = (p == rsh_pkg::POLICY_PRIO) || (p == rsh_pkg::POLICY_PINS);
  endfunction : is_auto

  // rail flags from the analog comparators, made in synchronous compare here
  logic rail_hit;
  assign rail_hit = (tune_level >= cur.upper) || (tune_level <= cur.lower);

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  always_comb begin
    logic [2:0]       policy;
    logic [2:0]       new_policy;
    logic             inv;
    logic             en_a;
    logic             en_b;
    logic             pa;
    logic             pb;
    logic             lock_s;
    logic             lock_fall;
    logic             hold_mode;
    logic             force_h;
    logic             track_on;
    logic             man_on;
    logic             rail_on;
    logic             ll_off;
    logic             lock_evt;
    logic             rail_evt;
    logic             event_ok;
    logic             want_b;
    logic             pins_valid;
    logic [DIV_W-1:0] div_val;
    policy     = '0;
    new_policy = '0;
    inv        = 1'b0;
    en_a       = 1'b0;
    en_b       = 1'b0;
    pa         = 1'b0;
    pb         = 1'b0;
    lock_s     = 1'b0;
    lock_fall  = 1'b0;
    hold_mode  = 1'b0;
    force_h    = 1'b0;
    track_on   = 1'b0;
    man_on     = 1'b0;
    rail_on    = 1'b0;
    ll_off     = 1'b0;
    lock_evt   = 1'b0;
    rail_evt   = 1'b0;
    event_ok   = 1'b0;
    want_b     = 1'b0;
    pins_valid = 1'b0;
    div_val    = '0;
    next_s     = cur;

    policy    = cur.ctrl[rsh_pkg::CTRL_POLICY_LSB +: 3];
    inv       = cur.ctrl[rsh_pkg::CTRL_INV_BIT];
    en_a      = cur.ctrl[rsh_pkg::CTRL_EN_A_BIT];
    en_b      = cur.ctrl[rsh_pkg::CTRL_EN_B_BIT];
    hold_mode = (cur.hold[rsh_pkg::HOLD_MODE_LSB +: 2] == rsh_pkg::HOLD_ENABLED);
    force_h   = cur.hold[rsh_pkg::HOLD_FORCE_BIT];
    track_on  = cur.hold[rsh_pkg::HOLD_TRACK_BIT];
    man_on    = cur.hold[rsh_pkg::HOLD_MAN_BIT];
    rail_on   = cur.hold[rsh_pkg::HOLD_RAIL_BIT];
    ll_off    = cur.hold[rsh_pkg::HOLD_LLOFF_BIT];
    div_val   = cur.hold[rsh_pkg::HOLD_DIV_LSB +: DIV_W];

    // two-stage synchronisers; the third lock stage is edge history
    next_s.lock_sync = {cur.lock_sync[1:0], loop1_raw_lock};
    next_s.pin_sync  = {cur.pin_sync[1:0], select_pin_b, select_pin_a};
    next_s.rail_sync = {cur.rail_sync[0], rail_hit};
    lock_s    = cur.lock_sync[1];
    lock_fall = cur.lock_sync[2] & ~lock_s;
    pa = cur.pin_sync[2] ^ inv;
    pb = cur.pin_sync[3] ^ inv;

    // pin decode: a wins, b only with a low, both low reserved
    pins_valid = pa | pb;
    want_b     = ~pa & pb;

    if (policy == rsh_pkg::POLICY_PRIO) begin
      lock_evt = lock_fall & ~ll_off;
    end else if (policy == rsh_pkg::POLICY_PINS) begin
      lock_evt = lock_fall;
    end
    // rail trip only counts with tracking and mode 2, in any policy
    rail_evt = rail_on && track_on && hold_mode && cur.rail_sync[1];

    // tracked level update on divided phase-detector ticks
    if (track_on && pd_tick) begin
      if (cur.div_cnt + DIV_W'(1) >= div_val) begin
        next_s.div_cnt = '0;
        if (!cur.hold_on) begin
          next_s.tracked = tune_level;
        end
      end else begin
        next_s.div_cnt = cur.div_cnt + DIV_W'(1);
      end
    end

    event_ok = (cur.st == rsh_pkg::ST_LOCKED);

    case (cur.st)
      rsh_pkg::ST_LOCKED: begin
        if ((lock_evt || rail_evt) && is_auto(policy)) begin
          if (policy == rsh_pkg::POLICY_PRIO) begin
            // rotate a -> b -> a, skipping disabled inputs
            if (cur.b_active ? en_a : en_b) begin
              next_s.b_active = ~cur.b_active;
            end
          end else if (pins_valid) begin
            next_s.b_active = want_b;
          end
          if (hold_mode || rail_evt) begin
            next_s.st = rsh_pkg::ST_HOLDOVER;
          end else begin
            next_s.st = rsh_pkg::ST_WAIT_RELOCK;
          end
          if (policy == rsh_pkg::POLICY_PINS && !pins_valid && !hold_mode) begin
            next_s.st = rsh_pkg::ST_LOCKED;
          end
        end else if (event_ok && (rail_evt || (hold_mode && !ll_off && lock_fall))) begin
          next_s.st = rsh_pkg::ST_HOLDOVER;
        end
      end
      rsh_pkg::ST_WAIT_RELOCK: begin
        if (lock_s) begin
          next_s.st = rsh_pkg::ST_LOCKED;
        end
      end
      rsh_pkg::ST_HOLDOVER: begin
        if (exit_ok && !force_h) begin
          next_s.st = rsh_pkg::ST_WAIT_RELOCK;
        end else if (!hold_mode && !force_h) begin
          next_s.st = rsh_pkg::ST_LOCKED;
        end
      end
      default: begin
        next_s.st = rsh_pkg::ST_LOCKED;
      end
    endcase

    // manual policies pin the active input
    if (policy == rsh_pkg::POLICY_MAN_A) begin
      next_s.b_active = 1'b0;
    end else if (policy == rsh_pkg::POLICY_MAN_B) begin
      next_s.b_active = 1'b1;
    end

    next_s.hold_on  = force_h || (next_s.st == rsh_pkg::ST_HOLDOVER);
    next_s.lock_out = lock_s && !next_s.hold_on;
    case (cur.ctrl[rsh_pkg::CTRL_LDSRC_LSB +: 2])
      rsh_pkg::LDSRC_LOCK1: next_s.ld_pin = next_s.lock_out;
      rsh_pkg::LDSRC_LOCK2: next_s.ld_pin = loop2_lock_flag;
      rsh_pkg::LDSRC_HOLD:  next_s.ld_pin = next_s.hold_on;
      default:              next_s.ld_pin = next_s.lock_out & loop2_lock_flag;
    endcase

    // apb slave, one wait state: answer prepared in the first access cycle
    next_s.pready  = req.psel && req.penable && !cur.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata  = '0;
    if (req.psel && req.penable && !cur.pready) begin
      if (req.paddr == rsh_pkg::OFF_CTRL) begin
        next_s.prdata = cur.ctrl;
      end else if (req.paddr == rsh_pkg::OFF_HOLD) begin
        next_s.prdata = cur.hold;
      end else if (req.paddr == rsh_pkg::OFF_TRIP) begin
        next_s.prdata = (32'(cur.upper) << 16) | 32'(cur.lower);
      end else if (req.paddr == rsh_pkg::OFF_MANUAL) begin
        next_s.prdata = 32'(cur.manual);
      end else if (req.paddr == rsh_pkg::OFF_STATUS) begin
        next_s.prdata = {26'h0000000, cur.st, loop2_lock_flag, cur.lock_out, cur.hold_on, cur.b_active};
      end else if (req.paddr == rsh_pkg::OFF_TRACKED) begin
        next_s.prdata = 32'(cur.tracked);
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    // writes land at the edge where pready is seen high
    if (req.psel && req.penable && req.pwrite && cur.pready) begin
      if (req.paddr == rsh_pkg::OFF_CTRL) begin
        next_s.ctrl = req.pwdata;
        new_policy  = req.pwdata[rsh_pkg::CTRL_POLICY_LSB +: 3];
        // entering auto policy while unlocked restarts from input a
        if (is_auto(new_policy) && !is_auto(policy) && !lock_s) begin
          next_s.b_active = 1'b0;
        end
      end else if (req.paddr == rsh_pkg::OFF_HOLD) begin
        next_s.hold = req.pwdata;
      end else if (req.paddr == rsh_pkg::OFF_TRIP) begin
        next_s.upper = req.pwdata[16 +: LEVEL_W];
        next_s.lower = req.pwdata[0 +: LEVEL_W];
      end else if (req.paddr == rsh_pkg::OFF_MANUAL) begin
        next_s.manual = req.pwdata[0 +: LEVEL_W];
      end
    end
    if (track_on && !man_on && rail_on) begin
      next_s.pslverr = next_s.pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur         <= '0;
      cur.ctrl    <= rsh_pkg::CTRL_RESET;
      cur.hold    <= rsh_pkg::HOLD_RESET;
      cur.upper   <= LEVEL_W'(rsh_pkg::UPPER_RESET);
      cur.lower   <= LEVEL_W'(rsh_pkg::LOWER_RESET);
      cur.manual  <= LEVEL_W'(rsh_pkg::MANUAL_RESET);
      cur.st      <= rsh_pkg::ST_LOCKED;
    end else begin
      cur <= next_s;
    end
  end

  // pump level: manual in fixed sub-mode, last tracked otherwise
  logic [LEVEL_W-1:0] level_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= '0;
    end else begin
      level_q <= cur.hold[rsh_pkg::HOLD_MAN_BIT] ? cur.manual : cur.tracked;
    end
  end

  assign prdata             = cur.prdata;
  assign pready             = cur.pready;
  assign pslverr            = cur.pslverr;
  assign ref_input_b_active = cur.b_active;
  assign holdover           = cur.hold_on;
  assign loop1_lock_flag    = cur.lock_out;
  assign loop1_pump_hiz     = cur.hold_on;
  assign loop1_pump_level   = level_q;
  assign lock_status_pin    = cur.ld_pin;

endmodule : rsh_ctrl

// ### rsh_ctrl_monitor.sv
// Purpose: port checks for rsh_ctrl
// Assumes: one clock pclk, async active low reset
// Notes: bound into every rsh_ctrl
`timescale 1ns/1ps
module rsh_ctrl_monitor #(
  parameter int LEVEL_W = 10
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [11:0]        paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               ref_input_b_active,
  input wire logic               holdover,
  input wire logic               loop1_lock_flag,
  input wire logic               loop1_pump_hiz,
  input wire logic [LEVEL_W-1:0] loop1_pump_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_after_setup_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("no answer after setup");
  answer_one_cycle_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  unmapped_refused_a: assert property (psel && penable && !pready && paddr > 12'h014 |=> pslverr)
    else $error("unmapped access not refused");
  error_in_access_a: assert property (pslverr |-> pready)
    else $error("error outside access phase");
  pump_tristate_a: assert property (loop1_pump_hiz == holdover)
    else $error("pump not tristated with holdover");
  hold_drops_lock_a: assert property (holdover |-> !loop1_lock_flag)
    else $error("lock flag high in holdover");
  hold_level_kept_a: assert property (holdover && $past(holdover) && $past(holdover, 2)
    && !$past(psel) && !$past(psel, 2) |-> $stable(loop1_pump_level))
    else $error("pump level moved in holdover");
  input_kept_a: assert property (loop1_lock_flag && $past(loop1_lock_flag) && $past(loop1_lock_flag, 2)
    && !$past(psel) && !$past(psel, 2) |-> $stable(ref_input_b_active))
    else $error("active input moved while locked");
endmodule : rsh_ctrl_monitor

bind rsh_ctrl rsh_ctrl_monitor #(.LEVEL_W(LEVEL_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .ref_input_b_active(ref_input_b_active),
  .holdover(holdover), .loop1_lock_flag(loop1_lock_flag), .loop1_pump_hiz(loop1_pump_hiz),
  .loop1_pump_level(loop1_pump_level)
);

// ### rsh_host_model.sv
// Purpose: host and loop side of rsh_ctrl
// Assumes: apb master, all changes right after a rising edge
// Notes: tb sets lock, pins and level here
`timescale 1ns/1ps
module rsh_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             pd_tick,
  output logic             lock,
  output logic             lock2,
  output logic             exit_ok,
  output logic [9:0]       tune_level,
  output logic             pin_a,
  output logic             pin_b
);
  logic [1:0] tick_cnt;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lock, lock2, exit_ok, pin_a, pin_b} = 5'h19;
    tune_level = 10'h200;
    tick_cnt = 2'h0;
    pd_tick = 1'b0;
  end
  // tick every 4 cycles, divider 4: update rate far below the limit
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    pd_tick <= (tick_cnt == 2'h3);
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : rsh_host_model

// ### rsh_pkg.sv
// Purpose: shared constants and types for the reference switch and holdover control
// Assumes: 32-bit apb, one clock pclk at 100 MHz
// Notes: all registers are one aligned word each
package rsh_pkg;

  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_HOLD    = 12'h004;
  localparam logic [11:0] OFF_TRIP    = 12'h008;
  localparam logic [11:0] OFF_MANUAL  = 12'h00C;
  localparam logic [11:0] OFF_STATUS  = 12'h010;
  localparam logic [11:0] OFF_TRACKED = 12'h014;

  // ctrl field positions
  localparam int CTRL_POLICY_LSB = 0;
  localparam int CTRL_INV_BIT    = 4;
  localparam int CTRL_EN_A_BIT   = 5;
  localparam int CTRL_EN_B_BIT   = 6;
  localparam int CTRL_LDSRC_LSB  = 8;
  // hold field positions
  localparam int HOLD_MODE_LSB   = 0;
  localparam int HOLD_FORCE_BIT  = 2;
  localparam int HOLD_TRACK_BIT  = 3;
  localparam int HOLD_MAN_BIT    = 4;
  localparam int HOLD_RAIL_BIT   = 5;
  localparam int HOLD_LLOFF_BIT  = 6;
  localparam int HOLD_DIV_LSB    = 16;

  localparam logic [2:0]  POLICY_MAN_A  = 3'h0;
  localparam logic [2:0]  POLICY_MAN_B  = 3'h1;
  localparam logic [2:0]  POLICY_PRIO   = 3'h4;
  localparam logic [2:0]  POLICY_PINS   = 3'h6;
  localparam logic [1:0]  HOLD_ENABLED  = 2'h2;
  localparam logic [1:0]  LDSRC_LOCK1   = 2'h0;
  localparam logic [1:0]  LDSRC_LOCK2   = 2'h1;
  localparam logic [1:0]  LDSRC_HOLD    = 2'h2;

  localparam logic [31:0] CTRL_RESET    = 32'h0000_0060;
  localparam logic [31:0] HOLD_RESET    = 32'h0004_0000;
  localparam logic [9:0]  UPPER_RESET   = 10'h3C0;
  localparam logic [9:0]  LOWER_RESET   = 10'h040;
  localparam logic [9:0]  MANUAL_RESET  = 10'h200;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rsh_apb_req_t;

  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_WAIT_RELOCK,
    ST_HOLDOVER
  } rsh_state_t;

endpackage : rsh_pkg

// ### tb.sv
// Purpose: self-checking bench for rsh_ctrl
// Assumes: 100 MHz pclk, lock and pins set via host model
// Notes: each scenario is one task
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pd_tick, lock, lock2, exit_ok, pin_a, pin_b;
  logic pready, pslverr, b_act, hold, lk1, hiz, lsp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] tune_level, level;
  logic err;
  int bad_count, check_count;
  rsh_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pd_tick(pd_tick), .lock(lock),
    .lock2(lock2), .exit_ok(exit_ok), .tune_level(tune_level), .pin_a(pin_a), .pin_b(pin_b));
  rsh_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_tick(pd_tick), .loop1_raw_lock(lock), .loop2_lock_flag(lock2), .exit_ok(exit_ok),
    .tune_level(tune_level), .select_pin_a(pin_a), .select_pin_b(pin_b), .ref_input_b_active(b_act),
    .holdover(hold), .loop1_lock_flag(lk1), .loop1_pump_hiz(hiz), .loop1_pump_level(level),
    .lock_status_pin(lsp));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, err);
    @(posedge pclk);
  endtask : wr
  task rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q, err);
    @(posedge pclk);
  endtask : rd
  task settle;
    repeat (8) @(posedge pclk);
  endtask : settle
  task ev(input logic a, input logic b, input logic e, input string n);
    host.pin_a <= a;
    host.pin_b <= b;
    settle;
    host.lock <= 1'b0;
    settle;
    chk(n, {31'h0, e}, {31'h0, b_act});
    host.lock <= 1'b1;
    settle;
  endtask : ev
  task t_regs;
    rd(12'h000);
    chk("ctrl", 32'h0000_0060, q);
    rd(12'h004);
    chk("hold", 32'h0004_0000, q);
    rd(12'h008);
    chk("trip", 32'h03C0_0040, q);
    rd(12'h018);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(12'h000, 32'h0000_0061);
    settle;
    chk("man b", 32'h1, {31'h0, b_act});
  endtask : t_regs
  task t_prio;
    wr(12'h000, 32'h0000_0064);
    settle;
    chk("prio start", 32'h1, {31'h0, b_act});
    ev(1'b1, 1'b0, 1'b0, "prio b to a");
    host.lock <= 1'b0;
    repeat (3) settle;
    chk("no repeat", 32'h1, {31'h0, b_act});
    host.lock <= 1'b1;
    settle;
    wr(12'h004, 32'h0004_0040);
    ev(1'b1, 1'b0, 1'b1, "trigger off");
    wr(12'h004, 32'h0004_0002);
    ev(1'b1, 1'b0, 1'b0, "hold event");
    host.lock <= 1'b0;
    settle;
    chk("hold on", 32'h2, {30'h0, hold, b_act});
    chk("hold lk", 32'h1, {31'h0, hiz & ~lk1});
    host.lock <= 1'b1;
    host.exit_ok <= 1'b1;
    settle;
    chk("hold exit", 32'h1, {30'h0, hold, lk1});
    host.exit_ok <= 1'b0;
  endtask : t_prio
  task t_pins;
    wr(12'h004, 32'h0004_0000);
    wr(12'h000, 32'h0000_0060);
    rd(12'h010);
    chk("lock ready", 32'h4, q & 32'h4);
    wr(12'h000, 32'h0000_0066);
    ev(1'b0, 1'b1, 1'b1, "pins b");
    ev(1'b0, 1'b0, 1'b1, "reserved");
    ev(1'b1, 1'b1, 1'b0, "pins a");
    wr(12'h000, 32'h0000_0076);
    ev(1'b1, 1'b0, 1'b1, "inverted");
  endtask : t_pins
  task t_hold;
    wr(12'h000, 32'h0000_0260);
    wr(12'h00C, 32'h0000_0155);
    wr(12'h004, 32'h0004_0014);
    settle;
    chk("forced", 32'h1, {31'h0, hold & lsp});
    chk("manual lvl", 32'h155, {22'h0, level});
    wr(12'h004, 32'h0004_0008);
    host.tune_level <= 10'h123;
    repeat (10) settle;
    chk("force off", 32'h0, {31'h0, hold});
    rd(12'h014);
    chk("tracked", 32'h123, q & 32'h3FF);
    wr(12'h004, 32'h0004_003A);
    host.tune_level <= 10'h3FF;
    settle;
    chk("rail", 32'h1, {31'h0, hold});
    chk("rail lvl", 32'h155, {22'h0, level});
    wr(12'h004, 32'h0004_0028);
    rd(12'h004);
    chk("bad submode", 32'h1, {31'h0, err});
  endtask : t_hold
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict;
  end
  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_prio;
    t_pins;
    t_hold;
    give_verdict;
  end
endmodule : tb
